// ===== rtl/keypad_wake_unit.sv
`timescale 1ns/10ps
`default_nettype none
module keypad_wake_unit #(
  parameter int unsigned PINS = keypad_pkg::PIN_COUNT
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [PINS-1:0] KEY_INPUT_PIN,
  input wire logic [PINS-1:0] PIN_DETECT_ENABLE,
  input wire logic [PINS-1:0] PIN_POLARITY_SELECT,
  input wire logic [PINS-1:0] PORT_PULL_ENABLE,
  input wire logic DETECT_LEVEL_SELECT,
  input wire logic KEY_IRQ_ENABLE,
  input wire logic KEY_FLAG_ACK,
  output logic KEY_EVENT_FLAG,
  output logic KEY_IRQ,
  output logic KEY_FLAG_ACK_READ,
  output logic [PINS-1:0] PULL_UP_EN,
  output logic [PINS-1:0] PULL_DOWN_EN
);
  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Map a sampled level to its asserted sense
  function automatic logic [PINS-1:0] to_asserted(
    input logic [PINS-1:0] level,
    input logic [PINS-1:0] polarity
  );
    to_asserted = level ^ ~polarity;
  endfunction

  // Keep only the bits selected by a mask
  function automatic logic [PINS-1:0] gate_enabled(
    input logic [PINS-1:0] bits,
    input logic [PINS-1:0] enable
  );
    gate_enabled = bits & enable;
  endfunction

  // Reduce a pin vector to one flag
  function automatic logic any_set(
    input logic [PINS-1:0] bits
  );
    any_set = |bits;
  endfunction

  // ---------------------------------------------------------------
  // Synchronise and normalise polarity
  // ---------------------------------------------------------------
  logic [PINS-1:0] pin_sync_w;
  logic [PINS-1:0] asserted_w;
  logic [PINS-1:0] asserted_prev_r;
  logic [PINS-1:0] enable_prev_r;

  pin_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .MCLK(MCLK),
    .RST(RST),
    .async_in(KEY_INPUT_PIN),
    .sync_out(pin_sync_w)
  );

  // Asserted level is 0 for falling polarity, 1 for rising
  assign asserted_w = to_asserted(pin_sync_w, PIN_POLARITY_SELECT);

  // ---------------------------------------------------------------
  // Detection terms
  // ---------------------------------------------------------------
  logic [PINS-1:0] active_w;
  logic any_asserted_w;
  logic all_idle_w;
  logic edge_w;
  logic level_w;
  logic set_w;
  logic clear_w;

  logic [PINS-1:0] was_idle_w;
  logic [PINS-1:0] pin_edge_w;

  assign active_w = gate_enabled(asserted_w, PIN_DETECT_ENABLE);
  assign any_asserted_w = any_set(active_w);
  assign all_idle_w = ~any_asserted_w;
  // Edge: deasserted last cycle, asserted now, pin enabled in both cycles
  assign was_idle_w = gate_enabled(~asserted_prev_r, enable_prev_r);
  assign pin_edge_w = gate_enabled(active_w, was_idle_w);
  assign edge_w = any_set(pin_edge_w);
  assign level_w = DETECT_LEVEL_SELECT & any_asserted_w;

  // ---------------------------------------------------------------
  // Arm state machine
  // ---------------------------------------------------------------
  keypad_pkg::arm_state_t arm_r;
  keypad_pkg::arm_state_t arm_nxt;
  logic edge_valid_w;

  logic arm_ready_w;

  assign arm_ready_w = (arm_r == keypad_pkg::ARM_READY);
  assign edge_valid_w = arm_ready_w & edge_w;

  always_comb begin
    arm_nxt = arm_r;
    case (arm_r)
      keypad_pkg::ARM_WAIT_IDLE: begin
        if (all_idle_w) begin
          arm_nxt = keypad_pkg::ARM_READY;
        end
      end
      keypad_pkg::ARM_READY: begin
        if (edge_w) begin
          arm_nxt = keypad_pkg::ARM_HELD;
        end
      end
      keypad_pkg::ARM_HELD: begin
        if (all_idle_w) begin
          arm_nxt = keypad_pkg::ARM_READY;
        end
      end
      default: begin
        arm_nxt = keypad_pkg::ARM_WAIT_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Event flag
  // ---------------------------------------------------------------
  logic flag_r;
  logic flag_nxt;

  assign set_w = edge_valid_w | level_w;
  assign clear_w = KEY_FLAG_ACK;
  // Set wins over acknowledge; level mode holds via level_w
  assign flag_nxt = set_w ? 1'h1 : (clear_w ? 1'h0 : flag_r);

  // ---------------------------------------------------------------
  // Arm state register
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      arm_r <= keypad_pkg::ARM_WAIT_IDLE;
    end else begin
      arm_r <= arm_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Event flag register
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      flag_r <= keypad_pkg::FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Previous asserted sense
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      asserted_prev_r <= keypad_pkg::SYNC_RST;
    end else begin
      asserted_prev_r <= asserted_w;
    end
  end

  // ---------------------------------------------------------------
  // Previous pin enables
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      enable_prev_r <= keypad_pkg::PIN_ENABLE_RST;
    end else begin
      enable_prev_r <= PIN_DETECT_ENABLE;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign KEY_EVENT_FLAG = flag_r;
  assign KEY_IRQ = flag_r & KEY_IRQ_ENABLE;
  assign KEY_FLAG_ACK_READ = 1'h0;
  assign PULL_UP_EN = gate_enabled(~PIN_POLARITY_SELECT, PORT_PULL_ENABLE);
  assign PULL_DOWN_EN = gate_enabled(PIN_POLARITY_SELECT, PORT_PULL_ENABLE);
endmodule // keypad_wake_unit
`default_nettype wire

// ===== rtl/keypad_pkg.sv
`default_nettype none
package keypad_pkg;
  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [7:0] PIN_ENABLE_RST = 8'h00;
  localparam logic [7:0] POLARITY_RST = 8'h00;
  localparam logic FLAG_RST = 1'h0;
  localparam logic [7:0] SYNC_RST = 8'h00;
  localparam logic POL_PULL_UP = 1'h0;
  localparam logic POL_PULL_DOWN = 1'h1;
  // ---------------------------------------------------------------
  // Arm state machine
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ARM_WAIT_IDLE = 2'h0,
    ARM_READY = 2'h1,
    ARM_HELD = 2'h3
  } arm_state_t;
endpackage
`default_nettype wire

// ===== rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // ---------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // pin_sync
`default_nettype wire

// ===== sim/keypad_wake_unit_properties.sv
`timescale 1ns/10ps
`default_nettype none
module keypad_wake_unit_properties #(parameter int unsigned PINS = 8) (
  input wire logic MCLK, RST, DETECT_LEVEL_SELECT, KEY_IRQ_ENABLE, KEY_FLAG_ACK,
  input wire logic KEY_EVENT_FLAG, KEY_IRQ, KEY_FLAG_ACK_READ,
  input wire logic [PINS-1:0] KEY_INPUT_PIN, PIN_DETECT_ENABLE, PIN_POLARITY_SELECT,
  input wire logic [PINS-1:0] PORT_PULL_ENABLE, PULL_UP_EN, PULL_DOWN_EN
);
  wire logic [PINS-1:0] hot = (KEY_INPUT_PIN ~^ PIN_POLARITY_SELECT) & PIN_DETECT_ENABLE;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  chk_irq_gate: assert property (KEY_IRQ == (KEY_EVENT_FLAG & KEY_IRQ_ENABLE)) else $error("irq");
  chk_ack_reads: assert property (!KEY_FLAG_ACK_READ) else $error("ack read");
  chk_pull_up: assert property (PULL_UP_EN == (PORT_PULL_ENABLE & ~PIN_POLARITY_SELECT)) else $error("up");
  chk_pull_down: assert property (PULL_DOWN_EN == (PORT_PULL_ENABLE & PIN_POLARITY_SELECT)) else $error("dn");
  chk_set_enabled: assert property ($rose(KEY_EVENT_FLAG) |-> |$past(PIN_DETECT_ENABLE)) else $error("set");
  chk_flag_holds: assert property (KEY_EVENT_FLAG && !KEY_FLAG_ACK |=> KEY_EVENT_FLAG) else $error("lost");
  chk_ack_clears: assert property (KEY_FLAG_ACK && PIN_DETECT_ENABLE == 0 |=> !KEY_EVENT_FLAG) else $error("ack");
  chk_level_keeps: assert property ((DETECT_LEVEL_SELECT && hot != 0) [*3] ##0 KEY_EVENT_FLAG
    |=> KEY_EVENT_FLAG) else $error("level");
  cover property ($rose(KEY_EVENT_FLAG));
  cover property (KEY_IRQ);
  cover property (DETECT_LEVEL_SELECT && KEY_FLAG_ACK && KEY_EVENT_FLAG);
endmodule // keypad_wake_unit_properties
bind keypad_wake_unit keypad_wake_unit_properties #(.PINS(PINS)) chk_i (.MCLK, .RST, .DETECT_LEVEL_SELECT,
  .KEY_IRQ_ENABLE, .KEY_FLAG_ACK, .KEY_EVENT_FLAG, .KEY_IRQ, .KEY_FLAG_ACK_READ, .KEY_INPUT_PIN,
  .PIN_DETECT_ENABLE, .PIN_POLARITY_SELECT, .PORT_PULL_ENABLE, .PULL_UP_EN, .PULL_DOWN_EN);
`default_nettype wire

// ===== sim/key_switches.sv
`timescale 1ns/10ps
`default_nettype none
module key_switches (
  input wire logic [7:0] press,
  output wire logic [7:0] pins
);
  // Contacts settle off the clock grid
  assign #7 pins = press;
endmodule // key_switches
`default_nettype wire

// ===== sim/keypad_wake_unit_test.sv
`timescale 1ns/10ps
`default_nettype none
module keypad_wake_unit_test;
  logic mclk = 0, rst = 1, lvl = 0, irqen = 0, ack = 0, flag, irq;
  logic [7:0] sw = 8'hFF, en = 8'h00, pol = 8'h00, pe = 8'h00, pu, pd;
  logic ar;
  wire logic [7:0] pins;
  logic [1:0] q[$];
  int miscompares = 0, tests_run = 0, k;
  event smp;
  always #25 mclk = ~mclk;
  key_switches sws (.press(sw), .pins(pins));
  keypad_wake_unit dut (.MCLK(mclk), .RST(rst), .KEY_INPUT_PIN(pins), .PIN_DETECT_ENABLE(en),
    .PIN_POLARITY_SELECT(pol), .PORT_PULL_ENABLE(pe), .DETECT_LEVEL_SELECT(lvl), .KEY_IRQ_ENABLE(irqen),
    .KEY_FLAG_ACK(ack), .KEY_EVENT_FLAG(flag), .KEY_IRQ(irq), .KEY_FLAG_ACK_READ(ar), .PULL_UP_EN(pu),
    .PULL_DOWN_EN(pd));
  always @(smp) begin
    tests_run++;
    if ({flag, irq} !== q.pop_front()) begin
      miscompares++;
      $display("CHECK FAILED %0t flag or irq", $time);
    end
  end
  task cyc(int n); repeat (n) @(negedge mclk); endtask
  task chk(logic [1:0] e); q.push_back(e); ->smp; endtask
  task pulse; ack <= 1; cyc(1); ack <= 0; endtask
  task cfg(logic [7:0] p, idle, e, logic l);
    irqen <= 0; en <= 8'h00; pol <= p; sw <= idle; lvl <= l; pe <= 8'($urandom);
    cyc(4); pulse; cyc(1); en <= e; cyc(4); pulse; cyc(1); irqen <= 1; cyc(1); tests_run++;
    if ({pu, pd, ar} !== {pe & ~p, pe & p, 1'b0}) begin
      miscompares++;
      $display("CHECK FAILED %0t pull or ack read", $time);
    end
  endtask
  task close_out;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h2BAAC6C8));
    cyc(5); rst <= 0;
    cfg(8'h00, 8'hFF, 8'hFF, 0); chk(2'b00);
    k = $urandom % 8;
    sw <= ~(8'h01 << k); cyc(4); chk(2'b11);
    sw <= 8'h00; pulse; cyc(4); chk(2'b00);
    sw <= 8'hFF; cyc(4); chk(2'b00);
    irqen <= 0; sw <= 8'hFE; cyc(4); chk(2'b10);
    cfg(8'hFF, 8'h00, 8'h01 << k, 0); chk(2'b00);
    sw <= ~(8'h01 << k); cyc(4); chk(2'b00);
    sw <= 8'h01 << k; cyc(4); chk(2'b11);
    cfg(8'h00, 8'hFF, 8'hFF, 1); chk(2'b00);
    sw <= 8'h7F; cyc(4); pulse; cyc(2); chk(2'b11);
    sw <= 8'hFF; cyc(4); pulse; cyc(1); chk(2'b00);
    close_out;
  end
  initial begin #50000; miscompares++; close_out; end
endmodule // keypad_wake_unit_test
`default_nettype wire
